// ===== ultd_regs.svh
`ifndef ULTD_REGS_SVH
`define ULTD_REGS_SVH

// register indices on the plain register port
`define ULTD_CTRL_ADDR        4'h0
`define ULTD_STAT_ADDR        4'h1
`define ULTD_RESET_ADDR       4'h2

// control register field positions
`define ULTD_XCVR_LSB         0
`define ULTD_TERM_BIT         2
`define ULTD_OPERATING_MODE_LSB       3
`define ULTD_DPREQ_BIT        5
`define ULTD_DMREQ_BIT        6

// reset values
`define ULTD_CTRL_RESET       8'h61
`define ULTD_RESET_BIT        0

// operating_mode and xcvr encodings
`define ULTD_OPERATING_MODE_NORMAL    2'h0
`define ULTD_OPERATING_MODE_TRISTATE  2'h1
`define ULTD_OPERATING_MODE_NODRIVE   2'h2
`define ULTD_XCVR_HS          2'h0

// internal reset duration in cycles
`define ULTD_SOFT_RESET_CYC   8'h08

`endif

// ===== ultd_pkg.sv
package ultd_pkg;
    typedef enum logic [1:0] {
        ULTD_IDLE  = 2'b00,
        ULTD_BUSY  = 2'b01,
        ULTD_DONE  = 2'b10
    } ultd_rst_state_t;

    typedef struct packed {
        logic       dm_req;
        logic       dp_req;
        logic [1:0] operating_mode;
        logic       term;
        logic [1:0] xcvr;
    } ultd_ctrl_t;
endpackage : ultd_pkg

// ===== ultd_decode.sv
`timescale 1ns/100ps
`include "ultd_regs.svh"

module ultd_decode (
    // control fields
    input  wire logic [1:0] xcvr,
    input  wire logic       term,
    input  wire logic [1:0] operating_mode,
    input  wire logic       dp_req,
    input  wire logic       dm_req,
    // resistor enables
    output logic            pullup_en,
    output logic            dp_pd_en,
    output logic            dm_pd_en,
    output logic            highspeed_termination_enable
);
    // pure table decode of the five fields
    always_comb begin
        if (operating_mode == `ULTD_OPERATING_MODE_TRISTATE) begin // [R07]
            pullup_en = 1'b0;
            dp_pd_en  = 1'b0;
            dm_pd_en  = 1'b0;
            highspeed_termination_enable = 1'b0;
        end else begin // [R02] [R18]
            dp_pd_en  = dp_req; // [R08] [R10] [R12]
            dm_pd_en  = dm_req; // [R16] [R17]
            highspeed_termination_enable = (xcvr == `ULTD_XCVR_HS) && !term; // [R09] [R15]
            pullup_en = term && !dp_req; // [R11] [R13] [R14]
        end
    end
endmodule : ultd_decode

// ===== ultd_top.sv
// What this block does
// (R01) line state chosen only from speed, termination, mode and two pull-down requests
// (R02) each resistor enable is a pure function of current field values
// (R03) link writes the field combination matching its wanted line state
// (R04) pull-up enable switches the 1.5 kohm resistor onto D+
// (R05) two pull-down enables each switch a 15 kohm resistor, D+ and D-
// (R06) termination enable switches 45 ohm terminations onto both lines
// (R07) mode 01b clears all four enables regardless of other fields
// (R08) power-up state enables both pull-downs only
// (R09) host chirp, high-speed, test: both pull-downs plus termination
// (R10) host full-speed and suspend: both pull-downs only
// (R11) host high/full-speed resume: both pull-downs, no pull-up or termination
// (R12) host low-speed and suspend: both pull-downs only
// (R13) host low-speed resume: both pull-downs, no pull-up or termination
// (R14) peripheral full-speed, suspend, resume: pull-up only
// (R15) peripheral high-speed and test: termination only
// (R16) peripheral chirp: pull-up, no termination, D- pull-down when requested
// (R17) OTG peripheral full-speed states: pull-up plus D- pull-down
// (R18) outside mode 01b: pull-downs mirror requests; termination and pull-up from fields
// (R19) enables registered, update two cycles after write, cleared by ARST_N reset
// (R20) reset bit holds direction high until reset ends, then self-clears
`timescale 1ns/100ps
`include "ultd_regs.svh"

module ultd_top (
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       ARST_N,
    // register port
    input  wire logic [3:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // link status
    output logic            LINK_DIR,
    output logic            RESET_DONE,
    // resistor enables
    output logic            DPLUS_PULLUP_ENABLE,
    output logic            DPLUS_PULLDOWN_ENABLE,
    output logic            DMINUS_PULLDOWN_ENABLE,
    output logic            HIGHSPEED_TERMINATION_ENABLE
);
    logic       rst_s1_reg;
    logic       rst_n;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       done_reg;
    logic       done_next;
    logic [3:0] en_reg;
    logic [3:0] en_next;
    logic       pu;
    logic       dpd;
    logic       dmd;
    logic       hst;
    ultd_pkg::ultd_ctrl_t    fields;
    ultd_pkg::ultd_rst_state_t st_reg;
    ultd_pkg::ultd_rst_state_t st_next;

    // reset release synchroniser
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    assign fields = ultd_pkg::ultd_ctrl_t'(ctrl_reg[6:0]); // [R01]

    // table decode
    ultd_decode u_decode (
        .xcvr      (fields.xcvr),
        .term      (fields.term),
        .operating_mode    (fields.operating_mode),
        .dp_req    (fields.dp_req),
        .dm_req    (fields.dm_req),
        .pullup_en (pu),
        .dp_pd_en  (dpd),
        .dm_pd_en  (dmd),
        .highspeed_termination_enable (hst)
    );

    // control register, read data, soft reset sequencer
    always_comb begin
        ctrl_next  = ctrl_reg;
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        done_next  = 1'b0;
        rdata_next = 8'h00;
        if (REG_WR && REG_ADDR == `ULTD_CTRL_ADDR && st_reg != ultd_pkg::ULTD_BUSY) begin
            ctrl_next = {1'b0, REG_WDATA[6:0]}; // [R03]
        end
        unique case (st_reg)
            ultd_pkg::ULTD_IDLE: begin
                if (REG_WR && REG_ADDR == `ULTD_RESET_ADDR && REG_WDATA[`ULTD_RESET_BIT]) begin
                    st_next  = ultd_pkg::ULTD_BUSY; // [R20]
                    cnt_next = `ULTD_SOFT_RESET_CYC;
                end
            end
            ultd_pkg::ULTD_BUSY: begin
                ctrl_next = `ULTD_CTRL_RESET;
                cnt_next  = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    st_next = ultd_pkg::ULTD_DONE;
                end
            end
            ultd_pkg::ULTD_DONE: begin
                done_next = 1'b1; // [R20]
                st_next   = ultd_pkg::ULTD_IDLE;
            end
            default: begin
                st_next = ultd_pkg::ULTD_IDLE;
            end
        endcase
        if (REG_RD) begin
            unique case (REG_ADDR)
                `ULTD_CTRL_ADDR:  rdata_next = ctrl_reg;
                `ULTD_STAT_ADDR:  rdata_next = {4'h0, en_reg};
                `ULTD_RESET_ADDR: rdata_next = {7'h00, st_reg == ultd_pkg::ULTD_BUSY};
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    // resistor enables follow the decode one cycle later
    always_comb begin
        en_next = {hst, dmd, dpd, pu}; // [R04] [R05] [R06] [R19]
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg  <= `ULTD_CTRL_RESET;
            st_reg    <= ultd_pkg::ULTD_IDLE;
            cnt_reg   <= 8'h00;
            done_reg  <= 1'b0;
            rdata_reg <= 8'h00;
            en_reg    <= 4'h0; // [R19]
        end else begin
            ctrl_reg  <= ctrl_next;
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            done_reg  <= done_next;
            rdata_reg <= rdata_next;
            en_reg    <= en_next;
        end
    end

    assign REG_RDATA                    = rdata_reg;
    assign LINK_DIR                     = (st_reg == ultd_pkg::ULTD_BUSY) || !rst_n; // [R20]
    assign RESET_DONE                   = done_reg;
    assign DPLUS_PULLUP_ENABLE          = en_reg[0];
    assign DPLUS_PULLDOWN_ENABLE        = en_reg[1];
    assign DMINUS_PULLDOWN_ENABLE       = en_reg[2];
    assign HIGHSPEED_TERMINATION_ENABLE = en_reg[3];
endmodule : ultd_top

// ===== ultd_link_model.sv
`timescale 1ns/100ps
module ultd_link_model (
    // bus
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [3:0] addr  = 4'h0,
    output logic      [7:0] wdata = 8'h00,
    output logic            wr    = 1'b0,
    output logic            rd    = 1'b0
);
    // link writes the field combination it wants
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
endmodule : ultd_link_model

// ===== ultd_top_assertions.sv
`timescale 1ns/100ps
module ultd_top_assertions (
    // clock, reset, bus
    input wire logic       CORE_CLK,
    input wire logic       ARST_N,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    // status and enables
    input wire logic       LINK_DIR,
    input wire logic       RESET_DONE,
    input wire logic       DPLUS_PULLUP_ENABLE,
    input wire logic       DPLUS_PULLDOWN_ENABLE,
    input wire logic       DMINUS_PULLDOWN_ENABLE,
    input wire logic       HIGHSPEED_TERMINATION_ENABLE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // accepted writes, enables as a nibble, expected decode of write data
    wire       cw   = REG_WR && REG_ADDR == 4'h0 && !LINK_DIR;
    wire       sr   = REG_WR && REG_ADDR == 4'h2 && REG_WDATA[0] && !LINK_DIR;
    wire       sts  = REG_RD && REG_ADDR == 4'h1;
    wire       live = REG_WDATA[4:3] != 2'h1;
    wire       pu   = REG_WDATA[2] && !REG_WDATA[5];
    wire       hs   = REG_WDATA[2:0] == 3'h0;
    wire [3:0] dec  = {hs, REG_WDATA[6:5], pu};
    wire [3:0] en   = {HIGHSPEED_TERMINATION_ENABLE, DMINUS_PULLDOWN_ENABLE,
                       DPLUS_PULLDOWN_ENABLE, DPLUS_PULLUP_ENABLE};
    a_tristate_off : assert property (
        cw && !live |-> ##2 en == 4'h0) else $error("tristate");
    a_field_decode : assert property (
        cw && live |-> ##2 en == $past(dec, 2)) else $error("decode");
    a_hsterm_both : assert property (
        cw && live |-> ##2 en[3] == $past(hs, 2)) else $error("term");
    a_pullup_dp : assert property (
        cw && live |-> ##2 en[0] == $past(pu, 2)) else $error("pullup");
    a_rdata_idle : assert property (
        !$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("rdata");
    a_status_read : assert property (
        $past(sts) |-> REG_RDATA == {4'h0, $past(en)}) else $error("status");
    a_soft_dir_len : assert property (
        sr |=> LINK_DIR [*8] ##1 !LINK_DIR) else $error("dir");
    a_soft_ctrl : assert property (
        sr |-> ##4 en == 4'h6) else $error("soft");
    a_done_pulse : assert property (
        sr |-> ##10 RESET_DONE ##1 !RESET_DONE) else $error("done pulse");
    // main scenarios
    c_tri : cover property (cw && !live);
    c_soft : cover property (sr ##10 RESET_DONE);
    c_sts : cover property (sts);
endmodule : ultd_top_assertions
bind ultd_top ultd_top_assertions chk (.*);

// ===== tb_usb_line_termination_decoder.sv
`timescale 1ns/100ps
module tb_usb_line_termination_decoder;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    wire  [3:0] addr;
    wire  [7:0] wdata;
    wire  [7:0] rdata;
    wire        wr;
    wire        rd;
    wire        dir;
    wire        done;
    wire  [3:0] en;
    logic [7:0] got;
    int         bad_count = 0;
    int         checks = 0;
    // expected enables {term, dm pd, dp pd, pull-up} above a control byte
    logic [11:0] rows [21] = '{12'h068, 12'h661, 12'hE70, 12'hE60, 12'h667, 12'h675,
        12'h666, 12'h676, 12'h114, 12'h800, 12'h105, 12'h115, 12'h810, 12'h554,
        12'hC40, 12'h545, 12'h555, 12'hC50, 12'h67F, 12'h11D, 12'h06F};
    // 10 MHz clock
    always #50 clk = ~clk;
    ultd_top dut (.CORE_CLK(clk), .ARST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .LINK_DIR(dir), .RESET_DONE(done),
        .DPLUS_PULLUP_ENABLE(en[0]), .DPLUS_PULLDOWN_ENABLE(en[1]),
        .DMINUS_PULLDOWN_ENABLE(en[2]), .HIGHSPEED_TERMINATION_ENABLE(en[3]));
    ultd_link_model link (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // watchdog
    initial begin
        #300000;
        bad_count++;
        final_report();
    end
    // reset values, table rows, then unmapped, soft reset and async reset cases
    initial begin
        repeat (5) @(posedge clk);
        chk("hold dir", 8'h01, {7'h00, dir});
        chk("hold en", 8'h00, {4'h0, en});
        chk("hold done", 8'h00, {7'h00, done});
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        link.rd_reg(4'h0, got);
        chk("reset ctrl", 8'h61, got);
        chk("reset en", 8'h06, {4'h0, en});
        foreach (rows[i]) begin
            link.wr_reg(4'h0, rows[i][7:0]);
            link.rd_reg(4'h1, got);
            chk("status", {4'h0, rows[i][11:8]}, got);
            chk("enables", {4'h0, rows[i][11:8]}, {4'h0, en});
            link.rd_reg(4'h0, got);
            chk("ctrl", {1'b0, rows[i][6:0]}, got);
        end
        link.wr_reg(4'hF, 8'h00);
        link.rd_reg(4'hF, got);
        chk("unmapped", 8'h00, got);
        link.wr_reg(4'h2, 8'h01);
        link.wr_reg(4'h0, 8'h00);
        link.rd_reg(4'h2, got);
        chk("busy", 8'h01, got);
        chk("dir", 8'h01, {7'h00, dir});
        repeat (3) @(posedge clk);
        #1;
        chk("dir last", 8'h01, {7'h00, dir});
        chk("done early", 8'h00, {7'h00, done});
        @(posedge clk);
        #1;
        chk("dir end", 8'h00, {7'h00, dir});
        @(posedge clk);
        #1;
        chk("done pulse", 8'h01, {7'h00, done});
        @(posedge clk);
        #1;
        chk("done end", 8'h00, {7'h00, done});
        link.rd_reg(4'h2, got);
        chk("cleared", 8'h00, got);
        link.rd_reg(4'h0, got);
        chk("ctrl soft", 8'h61, got);
        // move off the reset value so the second release proves it is restored
        link.wr_reg(4'h0, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk("async en", 8'h00, {4'h0, en});
        chk("async dir", 8'h01, {7'h00, dir});
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("rerun dir", 8'h00, {7'h00, dir});
        chk("rerun en", 8'h06, {4'h0, en});
        final_report();
    end
endmodule : tb_usb_line_termination_decoder
